/* File: shared/psc_pkg.sv */
// Functional notes
// - after init phase 1 ends, start self-test; rerun on failure up to repeat limit.
// - send busy or ready messages in init phase 3; busy count follows reruns.
// - a channel's self-test loop stops at the first passing sequence.
// - once self-test completes, send exactly two ready messages, then leave phase 3.
// - count reruns per channel, but both channels leave phase 3 together.
// - keep both channels busy until both passed or reruns are used up.
// - set the init done flag by hardware on leaving init phase 3.
// - asynchronous mode sends frames at a fixed period and ignores sync pulses.
// - in init phase 1 still pass sync pulses to programming entry decoding.
// - simultaneous mode latches the sample at the sync rising edge.
// - minimum latency mode latches the sample at the response start time.
// - unprogrammed part answers sync pulses in the default 16-bit CRC mode.
// - defaults stay in force until user OTP block two is written and locked.
// - frame is two start bits, sixteen data bits LSB first, CRC C2 to C0.
// - init frames carry six zero low bits and ten bits of init data.
// - default slots 47 us (0x002F) for channel 0 and 244 us (0x00F4).
// - default data size field 3'b100 and CRC enable bit 2 set.
// - default bit time field 4'b1000, 8.0 us per bit at 125 kbit/s.
// - high g default: range, sensitivity and low-pass fields all zero.
// - medium g default: same zero fields, 400 Hz four-pole response.
// - default offset cancellation field 2'b00, 0.04 Hz high-pass with limit.
package psc_pkg;

  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_SOURCE_ID_CONFIG_0 = 10'h01A;
  localparam logic [9:0] IDX_BIT_TIME_CONFIG    = 10'h023;
  localparam logic [9:0] IDX_LINK_CONFIG        = 10'h025;
  localparam logic [9:0] IDX_RESP_START_CH0     = 10'h026;
  localparam logic [9:0] IDX_RESP_START_CH1     = 10'h02A;
  localparam logic [9:0] IDX_CH0_USER_CONFIG_1  = 10'h040;
  localparam logic [9:0] IDX_CH0_USER_CONFIG_2  = 10'h041;
  localparam logic [9:0] IDX_CH0_USER_CONFIG_4  = 10'h043;
  localparam logic [9:0] IDX_CH1_USER_CONFIG_1  = 10'h048;
  localparam logic [9:0] IDX_CH1_USER_CONFIG_2  = 10'h049;
  localparam logic [9:0] IDX_CH1_USER_CONFIG_4  = 10'h04B;
  localparam logic [9:0] IDX_CTRL               = 10'h060;
  localparam logic [9:0] IDX_STATUS             = 10'h061;

  // reset values (default transmission settings)
  localparam logic [7:0]  RST_SOURCE_ID_CONFIG_0 = 8'h40;
  localparam logic [7:0]  RST_BIT_TIME_CONFIG    = 8'h08;
  localparam logic [7:0]  RST_LINK_CONFIG        = 8'h04;
  localparam logic [15:0] RST_RESP_START_CH0     = 16'h002F;
  localparam logic [15:0] RST_RESP_START_CH1     = 16'h00F4;
  localparam logic [7:0]  RST_USER_CONFIG        = 8'h00;
  localparam logic [7:0]  RST_CTRL               = 8'h30;

  // field positions
  localparam int CTRL_ASYNC_BIT = 0;
  localparam int CTRL_SS_BIT    = 1;
  localparam int CTRL_RPT_LSB   = 4;
  localparam int RPT_W          = 4;
  localparam int BIT_TIME_W     = 4;
  localparam int ST_DONE_BIT    = 0;
  localparam int ST_PHASE_LSB   = 1;
  localparam int ST_PASS_LSB    = 3;
  localparam int ST_RPT0_LSB    = 8;
  localparam int ST_RPT1_LSB    = 12;
  localparam int ST_LOCK_BIT    = 16;

  // timing
  localparam int CLK_PERIOD_NS       = 25;
  localparam int NS_PER_US           = 1000;
  localparam int CYC_PER_US          = NS_PER_US / CLK_PERIOD_NS;
  localparam int ASYNC_PERIOD_US_DEF = 228;

  // frame layout
  localparam int          DATA_BITS     = 16;
  localparam int          CRC_BITS      = 3;
  localparam int          START_BITS    = 2;
  localparam int          FRAME_BITS    = START_BITS + DATA_BITS + CRC_BITS;
  localparam int          INIT_PAD_BITS = 6;
  localparam logic [1:0]  START_VAL     = 2'b00;
  localparam logic [2:0]  CRC_SEED      = 3'b111;
  localparam logic [9:0]  INIT_BUSY_MSG  = 10'h155;
  localparam logic [9:0]  INIT_READY_MSG = 10'h2AA;
  localparam logic [1:0]  READY_MSGS    = 2'h2;

  typedef enum logic [1:0] {
    PH_INIT1    = 2'b00,
    PH_SELFTEST = 2'b01,
    PH_READY    = 2'b11,
    PH_NORMAL   = 2'b10
  } psc_phase_t;

endpackage

/* File: verilog/psc_sync_edge.sv */
`timescale 1ns/100ps
`default_nettype none
module psc_sync_edge (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // pin in, edge out
  input  wire logic sync_in,
  output logic      rise
);
  logic meta_r;
  logic sync_r;
  logic last_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end else begin
      meta_r <= sync_in;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign rise = sync_r & ~last_r;
endmodule // psc_sync_edge
`default_nettype wire

/* File: verilog/psc_frame_tx.sv */
`timescale 1ns/100ps
`default_nettype none
module psc_frame_tx #(
  parameter int DATA_W = psc_pkg::DATA_BITS
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // request
  input  wire logic              req,
  input  wire logic [DATA_W-1:0] data,
  input  wire logic [9:0]        bit_cyc,
  output logic                   ready,
  // line
  output logic                   tx_bit,
  output logic                   tx_active
);
  localparam int FB = psc_pkg::FRAME_BITS;

  logic [FB-1:0] shift_r;
  logic [4:0]    idx_r;
  logic [9:0]    cyc_r;
  logic [2:0]    crc;
  logic          bit_end;

  // crc over data bits in send order
  function automatic logic [2:0] crc3(input logic [DATA_W-1:0] d);
    logic [2:0] c;
    logic       fb;
    c = psc_pkg::CRC_SEED;
    for (int i = 0; i < DATA_W; i++) begin
      fb = c[2] ^ d[i];
      c  = {c[1], c[0] ^ fb, fb};
    end
    return c;
  endfunction

  assign crc     = crc3(data);
  assign ready   = ~tx_active;
  assign bit_end = (cyc_r == bit_cyc - 10'h001) || (bit_cyc == 10'h000);
  assign tx_bit  = shift_r[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_r   <= '0;
      idx_r     <= 5'h00;
      cyc_r     <= 10'h000;
      tx_active <= 1'b0;
    end else if (req && !tx_active) begin
      // start, data lsb first, crc msb first
      shift_r   <= {crc[0], crc[1], crc[2], data, psc_pkg::START_VAL};
      idx_r     <= 5'h00;
      cyc_r     <= 10'h000;
      tx_active <= 1'b1;
    end else if (tx_active) begin
      cyc_r <= bit_end ? 10'h000 : cyc_r + 10'h001;
      if (bit_end) begin
        shift_r <= shift_r >> 1;
        idx_r   <= idx_r + 5'h01;
        if (idx_r == 5'(FB - 1)) begin
          tx_active <= 1'b0;
        end
      end
    end
  end
endmodule // psc_frame_tx
`default_nettype wire

/* File: verilog/psc_init_sampling_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
module psc_init_sampling_ctrl #(
  parameter int ASYNC_PERIOD_US = psc_pkg::ASYNC_PERIOD_US_DEF
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // receiver link
  input  wire logic        sync_pulse_in,
  output logic             tx_bit,
  output logic             tx_active,
  output logic             tx_channel,
  // otp state
  input  wire logic        user_otp_block_two,
  // init sequencing
  input  wire logic        init_phase1_done,
  output logic             prog_sync_rise,
  output logic             init_done_flag,
  // self-test engine
  output logic [1:0]       selftest_start,
  input  wire logic [1:0]  selftest_done,
  input  wire logic [1:0]  selftest_pass,
  // sensor samples
  input  wire logic [15:0] ch0_sample,
  input  wire logic [15:0] ch1_sample
);

  // register file
  logic [7:0]  source_id_config_0_r;
  logic [7:0]  bit_time_config_r;
  logic [7:0]  link_config_r;
  logic [15:0] resp_start_time_ch0_r;
  logic [15:0] resp_start_time_ch1_r;
  logic [7:0]  user_config_1_r [2];
  logic [7:0]  user_config_2_r [2];
  logic [7:0]  user_config_4_r [2];
  logic [7:0]  ctrl_r;
  logic [31:0] prdata_r;

  // sequencing state
  psc_pkg::psc_phase_t phase_r;
  psc_pkg::psc_phase_t phase_nxt;
  logic [psc_pkg::RPT_W-1:0] selftest_repeat_limit_r [2];
  logic [1:0]  st_pass_r;
  logic [1:0]  st_fin_r;
  logic [1:0]  st_start_r;
  logic [1:0]  ready_cnt_r;
  logic        init_done_r;
  logic        msg_init_r;
  logic        msg_ready_r;

  // timing state
  logic [5:0]  presc_r;
  logic [15:0] slot_us_r;
  logic        slot_run_r;
  logic [1:0]  fired_r;
  logic [15:0] async_us_r;
  logic [15:0] smp0_r;
  logic [15:0] smp1_r;
  logic        tx_channel_r;

  // decode and datapath wires
  logic        setup;
  logic        wr_en;
  logic        hit;
  logic [31:0] rd_mux;
  logic        locked;
  logic        eff_async;
  logic        eff_ss;
  logic [15:0] eff_rsp0;
  logic [15:0] eff_rsp1;
  logic [psc_pkg::BIT_TIME_W-1:0] eff_bt;
  logic [9:0]  bit_cyc;
  logic        sync_rise;
  logic        us_tick;
  logic        async_tick;
  logic        trig;
  logic        fire0;
  logic        fire1;
  logic        tx_req;
  logic        tx_ready;
  logic [15:0] tx_data;
  logic [15:0] init_word;
  logic        in_init3;
  logic        leave_init3;

  function automatic logic sel(input logic [11:0] a, input logic [9:0] idx);
    return a[11:2] == idx;
  endfunction

  function automatic logic [7:0] lane(input logic [7:0] old, input logic en, input logic [7:0] nw);
    return en ? nw : old;
  endfunction

  // apb decode; zero wait states
  assign setup  = psel & ~penable;
  assign wr_en  = psel & penable & pwrite & hit;
  assign pready = 1'b1;
  assign hit = sel(paddr, psc_pkg::IDX_SOURCE_ID_CONFIG_0) | sel(paddr, psc_pkg::IDX_BIT_TIME_CONFIG)
             | sel(paddr, psc_pkg::IDX_LINK_CONFIG)       | sel(paddr, psc_pkg::IDX_RESP_START_CH0)
             | sel(paddr, psc_pkg::IDX_RESP_START_CH1)    | sel(paddr, psc_pkg::IDX_CH0_USER_CONFIG_1)
             | sel(paddr, psc_pkg::IDX_CH0_USER_CONFIG_2) | sel(paddr, psc_pkg::IDX_CH0_USER_CONFIG_4)
             | sel(paddr, psc_pkg::IDX_CH1_USER_CONFIG_1) | sel(paddr, psc_pkg::IDX_CH1_USER_CONFIG_2)
             | sel(paddr, psc_pkg::IDX_CH1_USER_CONFIG_4) | sel(paddr, psc_pkg::IDX_CTRL)
             | sel(paddr, psc_pkg::IDX_STATUS);
  assign pslverr = psel & penable & ~hit;
  assign prdata  = prdata_r;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (1'b1)
      sel(paddr, psc_pkg::IDX_SOURCE_ID_CONFIG_0): rd_mux[7:0]  = source_id_config_0_r;
      sel(paddr, psc_pkg::IDX_BIT_TIME_CONFIG):    rd_mux[7:0]  = bit_time_config_r;
      sel(paddr, psc_pkg::IDX_LINK_CONFIG):        rd_mux[7:0]  = link_config_r;
      sel(paddr, psc_pkg::IDX_RESP_START_CH0):     rd_mux[15:0] = resp_start_time_ch0_r;
      sel(paddr, psc_pkg::IDX_RESP_START_CH1):     rd_mux[15:0] = resp_start_time_ch1_r;
      sel(paddr, psc_pkg::IDX_CH0_USER_CONFIG_1):  rd_mux[7:0]  = user_config_1_r[0];
      sel(paddr, psc_pkg::IDX_CH0_USER_CONFIG_2):  rd_mux[7:0]  = user_config_2_r[0];
      sel(paddr, psc_pkg::IDX_CH0_USER_CONFIG_4):  rd_mux[7:0]  = user_config_4_r[0];
      sel(paddr, psc_pkg::IDX_CH1_USER_CONFIG_1):  rd_mux[7:0]  = user_config_1_r[1];
      sel(paddr, psc_pkg::IDX_CH1_USER_CONFIG_2):  rd_mux[7:0]  = user_config_2_r[1];
      sel(paddr, psc_pkg::IDX_CH1_USER_CONFIG_4):  rd_mux[7:0]  = user_config_4_r[1];
      sel(paddr, psc_pkg::IDX_CTRL):               rd_mux[7:0]  = ctrl_r;
      sel(paddr, psc_pkg::IDX_STATUS): begin
        rd_mux[psc_pkg::ST_DONE_BIT]                        = init_done_r;
        rd_mux[psc_pkg::ST_PHASE_LSB +: 2]                  = phase_r;
        rd_mux[psc_pkg::ST_PASS_LSB +: 2]                   = st_pass_r;
        rd_mux[psc_pkg::ST_RPT0_LSB +: psc_pkg::RPT_W]      = selftest_repeat_limit_r[0];
        rd_mux[psc_pkg::ST_RPT1_LSB +: psc_pkg::RPT_W]      = selftest_repeat_limit_r[1];
        rd_mux[psc_pkg::ST_LOCK_BIT]                        = locked;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // read data captured in setup, shown in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata_r <= rd_mux;
    end
  end

  // writable registers with byte lanes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      source_id_config_0_r  <= psc_pkg::RST_SOURCE_ID_CONFIG_0;
      link_config_r         <= psc_pkg::RST_LINK_CONFIG;
      bit_time_config_r     <= psc_pkg::RST_BIT_TIME_CONFIG;
      resp_start_time_ch0_r <= psc_pkg::RST_RESP_START_CH0;
      resp_start_time_ch1_r <= psc_pkg::RST_RESP_START_CH1;
      ctrl_r                <= psc_pkg::RST_CTRL;
    end else if (wr_en) begin
      if (sel(paddr, psc_pkg::IDX_SOURCE_ID_CONFIG_0)) begin
        source_id_config_0_r <= lane(source_id_config_0_r, pstrb[0], pwdata[7:0]);
      end
      if (sel(paddr, psc_pkg::IDX_BIT_TIME_CONFIG)) begin
        bit_time_config_r <= lane(bit_time_config_r, pstrb[0], pwdata[7:0]);
      end
      if (sel(paddr, psc_pkg::IDX_LINK_CONFIG)) begin
        link_config_r <= lane(link_config_r, pstrb[0], pwdata[7:0]);
      end
      if (sel(paddr, psc_pkg::IDX_RESP_START_CH0)) begin
        resp_start_time_ch0_r <= {lane(resp_start_time_ch0_r[15:8], pstrb[1], pwdata[15:8]),
                                  lane(resp_start_time_ch0_r[7:0], pstrb[0], pwdata[7:0])};
      end
      if (sel(paddr, psc_pkg::IDX_RESP_START_CH1)) begin
        resp_start_time_ch1_r <= {lane(resp_start_time_ch1_r[15:8], pstrb[1], pwdata[15:8]),
                                  lane(resp_start_time_ch1_r[7:0], pstrb[0], pwdata[7:0])};
      end
      if (sel(paddr, psc_pkg::IDX_CTRL)) begin
        ctrl_r <= lane(ctrl_r, pstrb[0], pwdata[7:0]);
      end
    end
  end

  // per-channel user configuration
  for (genvar c = 0; c < 2; c++) begin : g_ucfg
    localparam logic [9:0] OFS = (c == 1) ? 10'h008 : 10'h000;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        // zero range, gain, filter, offset fields
        user_config_1_r[c] <= psc_pkg::RST_USER_CONFIG;
        user_config_2_r[c] <= psc_pkg::RST_USER_CONFIG;
        user_config_4_r[c] <= psc_pkg::RST_USER_CONFIG;
      end else if (wr_en && pstrb[0]) begin
        if (sel(paddr, psc_pkg::IDX_CH0_USER_CONFIG_1 + OFS)) begin
          user_config_1_r[c] <= pwdata[7:0];
        end
        if (sel(paddr, psc_pkg::IDX_CH0_USER_CONFIG_2 + OFS)) begin
          user_config_2_r[c] <= pwdata[7:0];
        end
        if (sel(paddr, psc_pkg::IDX_CH0_USER_CONFIG_4 + OFS)) begin
          user_config_4_r[c] <= pwdata[7:0];
        end
      end
    end
  end

  // defaults until otp block two locked
  assign locked    = user_otp_block_two;
  assign eff_async = locked & ctrl_r[psc_pkg::CTRL_ASYNC_BIT];
  assign eff_ss    = locked & ctrl_r[psc_pkg::CTRL_SS_BIT];
  assign eff_rsp0  = locked ? resp_start_time_ch0_r : psc_pkg::RST_RESP_START_CH0;
  assign eff_rsp1  = locked ? resp_start_time_ch1_r : psc_pkg::RST_RESP_START_CH1;
  assign eff_bt    = locked ? bit_time_config_r[psc_pkg::BIT_TIME_W-1:0]
                            : psc_pkg::RST_BIT_TIME_CONFIG[psc_pkg::BIT_TIME_W-1:0];
  assign bit_cyc   = 10'(eff_bt) * 10'(psc_pkg::CYC_PER_US);

  psc_sync_edge u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .sync_in (sync_pulse_in),
    .rise    (sync_rise)
  );

  // sync edges always reach programming entry in phase 1
  assign prog_sync_rise = sync_rise & (phase_r == psc_pkg::PH_INIT1);

  assign us_tick    = presc_r == 6'(psc_pkg::CYC_PER_US - 1);
  assign async_tick = eff_async & us_tick & (async_us_r == 16'(ASYNC_PERIOD_US - 1));
  assign trig       = (eff_async ? async_tick : sync_rise) & (phase_r != psc_pkg::PH_INIT1);

  // slot fires when microsecond count meets response start time
  assign fire0 = slot_run_r & ~fired_r[0] & (slot_us_r == eff_rsp0);
  assign fire1 = slot_run_r & ~fired_r[1] & (slot_us_r == eff_rsp1) & ~fire0;

  // prescaler restarts on trigger so slots align to the edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_r    <= 6'h00;
      async_us_r <= 16'h0000;
    end else begin
      presc_r <= (trig || us_tick) ? 6'h00 : presc_r + 6'h01;
      if (!eff_async || async_tick) begin
        async_us_r <= 16'h0000;
      end else if (us_tick) begin
        async_us_r <= async_us_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_us_r  <= 16'h0000;
      slot_run_r <= 1'b0;
      fired_r    <= 2'b00;
    end else if (trig) begin
      slot_us_r  <= 16'h0000;
      slot_run_r <= 1'b1;
      fired_r    <= 2'b00;
    end else begin
      fired_r <= fired_r | {fire1, fire0};
      if ((fired_r | {fire1, fire0}) == 2'b11) begin
        slot_run_r <= 1'b0;
      end else if (us_tick && slot_run_r) begin
        slot_us_r <= slot_us_r + 16'h0001;
      end
    end
  end

  // simultaneous mode latches at the sync edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smp0_r <= 16'h0000;
      smp1_r <= 16'h0000;
    end else if (trig) begin
      smp0_r <= ch0_sample;
      smp1_r <= ch1_sample;
    end
  end

  // init frame: six zero bits below the message
  assign init_word = msg_ready_r ? {psc_pkg::INIT_READY_MSG, {psc_pkg::INIT_PAD_BITS{1'b0}}}
                                 : {psc_pkg::INIT_BUSY_MSG, {psc_pkg::INIT_PAD_BITS{1'b0}}};
  // minimum latency takes the live sample at slot time
  assign tx_data = msg_init_r ? init_word
                 : fire0      ? (eff_ss ? smp0_r : ch0_sample)
                              : (eff_ss ? smp1_r : ch1_sample);
  // a slot that meets a busy line is dropped
  assign tx_req  = fire0 | fire1;

  psc_frame_tx #(
    .DATA_W (psc_pkg::DATA_BITS)
  ) u_tx (
    .pclk      (pclk),
    .presetn   (presetn),
    .req       (tx_req),
    .data      (tx_data),
    .bit_cyc   (bit_cyc),
    .ready     (tx_ready),
    .tx_bit    (tx_bit),
    .tx_active (tx_active)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_channel_r <= 1'b0;
    end else if (tx_req && tx_ready) begin
      tx_channel_r <= fire1;
    end
  end
  assign tx_channel = tx_channel_r;

  // self-test per channel
  for (genvar c = 0; c < 2; c++) begin : g_st
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        selftest_repeat_limit_r[c]   <= '0;
        st_pass_r[c]  <= 1'b0;
        st_fin_r[c]   <= 1'b0;
        st_start_r[c] <= 1'b0;
      end else if (phase_r == psc_pkg::PH_INIT1 && init_phase1_done) begin
        // start on end of phase 1
        selftest_repeat_limit_r[c]   <= '0;
        st_pass_r[c]  <= 1'b0;
        st_fin_r[c]   <= 1'b0;
        st_start_r[c] <= 1'b1;
      end else if (phase_r == psc_pkg::PH_SELFTEST && selftest_done[c] && !st_fin_r[c]) begin
        if (selftest_pass[c]) begin
          st_pass_r[c]  <= 1'b1;
          st_fin_r[c]   <= 1'b1;
          st_start_r[c] <= 1'b0;
        end else if (selftest_repeat_limit_r[c] == ctrl_r[psc_pkg::CTRL_RPT_LSB +: psc_pkg::RPT_W]) begin
          st_fin_r[c]   <= 1'b1;
          st_start_r[c] <= 1'b0;
        end else begin
          selftest_repeat_limit_r[c]   <= selftest_repeat_limit_r[c] + 1'b1;
          st_start_r[c] <= 1'b1;
        end
      end else begin
        st_start_r[c] <= 1'b0;
      end
    end
  end
  assign selftest_start = st_start_r;

  // phase 3 held until both channels finish
  assign in_init3    = (phase_r == psc_pkg::PH_SELFTEST) | (phase_r == psc_pkg::PH_READY);
  // leave at the second ready slot of channel 1
  assign leave_init3 = (phase_r == psc_pkg::PH_READY) & fire1 & msg_ready_r
                     & (ready_cnt_r == psc_pkg::READY_MSGS - 2'h1);

  always_comb begin
    phase_nxt = phase_r;
    case (phase_r)
      psc_pkg::PH_INIT1:    phase_nxt = init_phase1_done ? psc_pkg::PH_SELFTEST : psc_pkg::PH_INIT1;
      psc_pkg::PH_SELFTEST: phase_nxt = (&st_fin_r) ? psc_pkg::PH_READY : psc_pkg::PH_SELFTEST;
      psc_pkg::PH_READY:    phase_nxt = leave_init3 ? psc_pkg::PH_NORMAL : psc_pkg::PH_READY;
      psc_pkg::PH_NORMAL:   phase_nxt = psc_pkg::PH_NORMAL;
      default:              phase_nxt = psc_pkg::PH_INIT1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r     <= psc_pkg::PH_INIT1;
      msg_init_r  <= 1'b0;
      msg_ready_r <= 1'b0;
      ready_cnt_r <= 2'h0;
      init_done_r <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      // message kind fixed per sync so both slots agree
      if (trig) begin
        msg_init_r  <= in_init3;
        msg_ready_r <= phase_r == psc_pkg::PH_READY;
      end
      if (phase_r == psc_pkg::PH_READY && fire1 && msg_ready_r) begin
        ready_cnt_r <= ready_cnt_r + 2'h1;
      end
      // flag set on exit from phase 3
      if (leave_init3) begin
        init_done_r <= 1'b1;
      end
    end
  end
  assign init_done_flag = init_done_r;

endmodule // psc_init_sampling_ctrl
`default_nettype wire

/* File: tb/psc_chk_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module psc_chk (
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // watched ports
  input wire logic       sync_pulse_in,
  input wire logic       prog_sync_rise,
  input wire logic       init_phase1_done,
  input wire logic       init_done_flag,
  input wire logic [1:0] selftest_start,
  input wire logic       tx_bit,
  input wire logic       tx_active
);
  logic [15:0] cnt_r;
  // frame length in cycles, default bit time only
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) cnt_r <= 16'h0000;
    else cnt_r <= tx_active ? cnt_r + 16'h0001 : 16'h0000;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_st_go; init_phase1_done && !init_done_flag |=> selftest_start == 2'b11; endproperty
  a_st_go: assert property (p_st_go) else $error("self-test not started");
  property p_st_one; selftest_start[1] |=> !selftest_start[1]; endproperty
  a_st_one: assert property (p_st_one) else $error("start pulse too long");
  property p_done_hold; init_done_flag |=> init_done_flag; endproperty
  a_done_hold: assert property (p_done_hold) else $error("init flag dropped");
  property p_sync_lat; prog_sync_rise |-> $past(sync_pulse_in, 2); endproperty
  a_sync_lat: assert property (p_sync_lat) else $error("sync edge latency");
  property p_sync_one; prog_sync_rise |=> !prog_sync_rise; endproperty
  a_sync_one: assert property (p_sync_one) else $error("sync edge too long");
  property p_start_bits; $rose(tx_active) |-> !tx_bit [*8]; endproperty
  a_start_bits: assert property (p_start_bits) else $error("start bit not low");
  property p_idle_low; !tx_active |-> !tx_bit; endproperty
  a_idle_low: assert property (p_idle_low) else $error("line not idle low");
  property p_frame_len; $fell(tx_active) |-> cnt_r == 16'h1A40; endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame length wrong");
endmodule // psc_chk
`default_nettype wire

/* File: tb/psc_rx_model.sv */
`timescale 1ns/100ps
`default_nettype none
module psc_rx_model #(parameter int PERIOD = 18000) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // sync line
  output logic      sync_out
);
  logic [15:0] cnt_r;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) {cnt_r, sync_out} <= 17'h00000;
    else begin
      cnt_r    <= (cnt_r == PERIOD - 1) ? 16'h0000 : cnt_r + 16'h0001;
      sync_out <= cnt_r < 16'h0028;
    end
endmodule // psc_rx_model
`default_nettype wire

/* File: tb/psi5_init_and_sampling_ctrl_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module psi5_init_and_sampling_ctrl_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sync_pulse_in, tx_bit, tx_active, tx_channel;
  logic        user_otp_block_two, init_phase1_done, prog_sync_rise, init_done_flag, fail1_r, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [1:0]  selftest_start, selftest_done, selftest_pass;
  logic [15:0] ch0_sample, ch1_sample;
  logic [31:0] seed;
  logic [20:0] fr;
  int          n_mismatch, num_checks, cyc;
  logic [9:0]  ix [6] = '{10'h01A, 10'h023, 10'h025, 10'h026, 10'h02A, 10'h040};
  logic [7:0]  ev [6] = '{8'h40, 8'h08, 8'h04, 8'h2F, 8'hF4, 8'h00};
  psc_init_sampling_ctrl #(.ASYNC_PERIOD_US(5)) u_dut (.*);
  psc_rx_model u_rx (.pclk(pclk), .presetn(presetn), .sync_out(sync_pulse_in));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // self-test engine: ch1 fails its first run
  always @(posedge pclk) begin
    selftest_done <= selftest_start;
    selftest_pass <= selftest_start & {~fail1_r, 1'b1};
    if (selftest_done[1]) fail1_r <= 1'b0;
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_mismatch++;
      summarize();
    end
  end
  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction
  function automatic logic [31:0] frame(input logic [15:0] d);
    logic [2:0] c;
    logic       fb;
    logic [20:0] f;
    c = 3'h7;
    f = 21'h0;
    for (int i = 0; i < 16; i++) begin
      fb = c[2] ^ d[i];
      c = {c[1], c[0] ^ fb, fb};
      f[18-i] = d[i];
    end
    return {11'h0, f[20:3], c};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ap(input logic w, input logic [9:0] i, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, i, 2'b00, d};
    @(posedge pclk) penable <= 1'b1;
    @(posedge pclk);
    while (!pready) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cap();
    while (tx_active) @(posedge pclk);
    while (!tx_active) @(posedge pclk);
    repeat (160) @(posedge pclk);
    for (int b = 0; b < 21; b++) begin
      fr = {fr[19:0], tx_bit};
      repeat (320) @(posedge pclk);
    end
  endtask
  task automatic summarize();
    if (n_mismatch == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, user_otp_block_two, init_phase1_done} = '0;
    {selftest_done, selftest_pass, fail1_r, pstrb, seed, n_mismatch, num_checks, cyc} = {5'h01, 4'hF, 32'h0000_8FEE, 96'h0};
    {ch0_sample, ch1_sample} = 32'h0;
    repeat (12) @(posedge pclk);
    {presetn, ch0_sample, ch1_sample} <= {1'b1, rnd(), rnd()};
    for (int k = 0; k < 6; k++) begin
      ap(1'b0, ix[k], 32'h0);
      chk(rd, {24'h0, ev[k]});
    end
    ap(1'b1, 10'h041, {16'h0, ch0_sample});
    ap(1'b0, 10'h041, 32'h0);
    chk(rd, {24'h0, ch0_sample[7:0]});
    ap(1'b0, 10'h3FF, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    init_phase1_done <= 1'b1;
    @(posedge pclk) init_phase1_done <= 1'b0;
    cap();
    chk({11'h0, fr}, frame({psc_pkg::INIT_READY_MSG, 6'h00}));
    while (!init_done_flag) @(posedge pclk);
    chk({31'h0, tx_channel}, 32'h1);
    ap(1'b0, 10'h061, 32'h0);
    chk(rd, 32'h0000101D);
    repeat (6722) @(posedge pclk);
    cap();
    chk({11'h0, fr}, frame(ch0_sample));
    ap(1'b1, psc_pkg::IDX_RESP_START_CH0, 32'h0000_0001);
    ap(1'b1, psc_pkg::IDX_CTRL, 32'h0000_0033);
    user_otp_block_two <= 1'b1;
    cap();
    chk({11'h0, fr}, frame(ch0_sample));
    chk({31'h0, tx_channel}, 32'h0);
    summarize();
  end
endmodule // psi5_init_and_sampling_ctrl_tb
bind psc_init_sampling_ctrl psc_chk u_chk (.pclk, .presetn, .sync_pulse_in, .prog_sync_rise, .init_phase1_done,
  .init_done_flag, .selftest_start, .tx_bit, .tx_active);
`default_nettype wire
